// ==== hw/layout_pkg.sv ====
/*
 * constants, types and register map of the save-area layout block.
 * assumes a 32-bit AHB-Lite slave port and a 64-byte aligned save-area base.
 */
package layout_pkg;
	localparam int NUM_COMP = 8;
	localparam int FIRST_EXT = 2;
	localparam int ALIGN_BITS = 6;
	localparam int FORMAT_BIT = 31;
	localparam int CAPS_COMPACT_BIT = 1;
	localparam logic COMPACT_SUPPORT = 1'b1;

	// area geometry, byte offsets from the save-area base
	localparam logic [15:0] LEGACY_OFF = 16'h0000;
	localparam logic [15:0] LEGACY_SIZE = 16'h0200;
	localparam logic [15:0] HDR_OFF = 16'h0200;
	localparam logic [15:0] EXT_OFF = 16'h0240;
	localparam logic [15:0] FP_LO_END = 16'h0017;
	localparam logic [15:0] SIMD_LO_END = 16'h001f;
	localparam logic [15:0] FP_HI_END = 16'h009f;
	localparam logic [15:0] SIMD_HI_END = 16'h019f;
	localparam logic [15:0] RSVD_END = 16'h01cf;
	localparam logic [15:0] LEGACY_END = 16'h01ff;
	localparam logic [15:0] PRESENT_END = 16'h0207;
	localparam logic [15:0] COMPACT_END = 16'h020f;
	localparam logic [15:0] HDR_END = 16'h023f;

	// per-component size and standard offset, index 7 leftmost
	localparam logic [NUM_COMP-1:0][15:0] COMP_SIZE_TBL =
		{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'h0000};
	localparam logic [NUM_COMP-1:0][15:0] COMP_STD_OFF_TBL =
		{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0240, 16'h0000, 16'h0000};

	// register byte addresses
	localparam logic [7:0] A_BASE = 8'h00;
	localparam logic [7:0] A_PRESENT_LO = 8'h04;
	localparam logic [7:0] A_PRESENT_HI = 8'h08;
	localparam logic [7:0] A_COMPACT_LO = 8'h0c;
	localparam logic [7:0] A_COMPACT_HI = 8'h10;
	localparam logic [7:0] A_USER_MASK = 8'h14;
	localparam logic [7:0] A_SUPV_MASK = 8'h18;
	localparam logic [7:0] A_COMP_SEL = 8'h1c;
	localparam logic [7:0] A_COMP_OFFSET = 8'h20;
	localparam logic [7:0] A_COMP_ADDR = 8'h24;
	localparam logic [7:0] A_COMP_SIZE = 8'h28;
	localparam logic [7:0] A_STATUS = 8'h2c;
	localparam logic [7:0] A_AREA_SIZE = 8'h30;
	localparam logic [7:0] A_CAPS = 8'h34;
	localparam logic [7:0] A_PROBE_OFF = 8'h38;
	localparam logic [7:0] A_PROBE_REGION = 8'h3c;

	// status bit positions
	localparam int ST_COMPACTED = 0;
	localparam int ST_RESTORE_COMPACTED = 1;
	localparam int ST_PRESENT = 2;
	localparam int ST_IN_AREA = 3;
	localparam int ST_MISALIGNED = 4;
	localparam int ST_FMT_ERR = 5;

	// reset values
	localparam logic [31:0] BASE_RST = 32'h00000000;
	localparam logic [31:0] BITMAP_RST = 32'h00000000;
	localparam logic [31:0] USER_MASK_RST = 32'h00000001;
	localparam logic [31:0] SUPV_MASK_RST = 32'h00000000;
	localparam logic [5:0] SEL_RST = 6'h00;
	localparam logic [15:0] PROBE_RST = 16'h0000;

	typedef enum logic [2:0] {
		RG_FP = 3'b000,
		RG_SIMD = 3'b001,
		RG_UNUSED = 3'b010,
		RG_RSVD = 3'b011,
		RG_PRESENT = 3'b100,
		RG_COMPACT = 3'b101,
		RG_HDR_RSVD = 3'b110,
		RG_EXT = 3'b111
	} region_t;

	typedef struct packed {
		logic [31:0] comp_addr;
		logic [15:0] comp_size;
		logic comp_in_area;
		logic comp_present;
		logic compacted;
		logic restore_compacted;
	} layout_t;
endpackage

// ==== hw/state_save_area_layout.sv ====
/*
 * save-area layout engine: holds the header bitmaps, enable masks and the
 * area base, and works out where each state component sits in memory.
 * assumes a single-master AHB-Lite bus on hclk and word-sized accesses.
 */
//
// Contract
// R1: issuer supplies a save-area base aligned to 64 bytes.
// R2: legacy region is the 512 bytes at the base.
// R3: 64-byte header starts 512 bytes above the base.
// R4: extended region starts at 576 and holds components 2 and up.
// R5: extended size follows supported components and user-or-supervisor mask bits; in compacted format the code sizes the area by the compaction bitmap instead.
// R6: floating-point stack state uses legacy bytes 23:0 and 159:32.
// R7: simd state uses legacy bytes 31:24 and 415:160.
// R8: legacy bytes 511:416 hold no state; 463:416 are reserved.
// R9: header bytes 7:0 are the present-components bitmap.
// R10: header bytes 15:8 are the compaction bitmap; bit 63 picks format.
// R11: compaction bit 63 set selects compacted restore, else standard.
// R12: software keeps compaction bitmap zero without compaction support.
// R13: header bytes 63:16 are reserved.
// R14: standard format puts each component at its fixed reported offset.
// R15: compacted format omits components whose compaction bit is clear.
// R16: lowest selected component in bits 62:2 sits at offset 576.
// R17: later selected components follow the previous one by its size.
// R18: only component 2, the wide-vector upper halves, is extended.
// R19: standard always supported; compacted only with compaction extensions.
// R20: compaction support reported in bit 1 of the capability word.
// R21: each supported component's byte size is reported.
// R22: offsets are derived combinationally from base, format bit and bitmap.
`timescale 1ns/1ns
module state_save_area_layout (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// layout of the selected component, towards the save/restore sequencer
	output layout_pkg::layout_t layout
);
	import layout_pkg::*;

	logic [31:0] base_r;
	logic [31:0] present_lo_r;
	logic [31:0] present_hi_r;
	logic [31:0] compact_lo_r;
	logic [31:0] compact_hi_r;
	logic [31:0] user_mask_r;
	logic [31:0] supv_mask_r;
	logic [5:0] sel_r;
	logic [15:0] probe_r;
	logic misalign_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic rd_pend_r;
	logic [7:0] rd_addr_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	layout_t layout_r;
	region_t region_r;

	logic xfer;
	logic fmt_req;
	logic compacted;
	logic fmt_err;
	logic [NUM_COMP-1:0] cbits;
	logic [NUM_COMP-1:0] enabled;
	logic [NUM_COMP-1:0] supported;
	logic [NUM_COMP-1:0][15:0] comp_off;
	logic [NUM_COMP-1:0] comp_in;
	logic [2:0] idx;
	logic sel_ok;
	logic [15:0] sel_off;
	logic [15:0] sel_size;
	logic [15:0] std_area;
	logic [15:0] area_size;
	layout_t lay;
	region_t region;
	logic [31:0] rd_word;

	// bytes taken by the extended components in mask that sit below component limit
	function automatic logic [15:0] sum_sizes(input logic [NUM_COMP-1:0] mask,
		input int limit);
		logic [15:0] acc;
		acc = 16'h0000;
		for (int j = FIRST_EXT; j < NUM_COMP; j++) begin
			if (j < limit && mask[j]) begin
				acc = acc + COMP_SIZE_TBL[j];
			end
		end
		return acc;
	endfunction

	// which part of the area a byte offset falls in
	function automatic region_t region_of(input logic [15:0] off);
		if (off <= FP_LO_END) begin
			return RG_FP;
		end else if (off <= SIMD_LO_END) begin
			return RG_SIMD;
		end else if (off <= FP_HI_END) begin
			return RG_FP;
		end else if (off <= SIMD_HI_END) begin
			return RG_SIMD;
		end else if (off <= RSVD_END) begin
			return RG_RSVD;
		end else if (off <= LEGACY_END) begin
			return RG_UNUSED;
		end else if (off <= PRESENT_END) begin
			return RG_PRESENT;
		end else if (off <= COMPACT_END) begin
			return RG_COMPACT;
		end else if (off <= HDR_END) begin
			return RG_HDR_RSVD;
		end else begin
			return RG_EXT;
		end
	endfunction

	assign xfer = hsel && htrans[1] && hready;

	// format selection; a compacted request without support falls back to standard
	assign fmt_req = compact_hi_r[FORMAT_BIT]; // [R10]
	assign compacted = fmt_req && COMPACT_SUPPORT; // [R11] [R19]
	assign fmt_err = fmt_req && !COMPACT_SUPPORT; // [R19]
	assign cbits = compact_lo_r[NUM_COMP-1:0];
	assign enabled = user_mask_r[NUM_COMP-1:0] | supv_mask_r[NUM_COMP-1:0];

	// per-component offset and presence, all combinational
	for (genvar i = 0; i < NUM_COMP; i++) begin : g_comp
		if (i < FIRST_EXT) begin : g_legacy
			assign supported[i] = 1'b1;
			assign comp_off[i] = LEGACY_OFF; // [R2] [R6] [R7]
			assign comp_in[i] = 1'b1;
		end else begin : g_ext
			assign supported[i] = (COMP_SIZE_TBL[i] != 16'h0000); // [R18] [R21]
			// [R16] [R17] [R22]
			assign comp_off[i] = compacted ? EXT_OFF + sum_sizes(cbits & supported, i)
				: COMP_STD_OFF_TBL[i]; // [R14]
			assign comp_in[i] = supported[i] && (compacted ? cbits[i] : enabled[i]); // [R15]
		end
	end

	assign sel_ok = (sel_r < 6'(NUM_COMP));
	assign idx = sel_r[2:0];
	assign sel_off = sel_ok ? comp_off[idx] : 16'h0000;
	assign sel_size = !sel_ok ? 16'h0000 : (idx < 3'(FIRST_EXT)) ? LEGACY_SIZE
		: COMP_SIZE_TBL[idx]; // [R21]

	// standard area ends after the highest enabled component
	always_comb begin
		std_area = EXT_OFF; // [R4]
		for (int k = FIRST_EXT; k < NUM_COMP; k++) begin
			if (supported[k] && enabled[k] &&
				COMP_STD_OFF_TBL[k] + COMP_SIZE_TBL[k] > std_area) begin
				std_area = COMP_STD_OFF_TBL[k] + COMP_SIZE_TBL[k];
			end
		end
	end

	assign area_size = compacted ? EXT_OFF + sum_sizes(cbits & supported, NUM_COMP)
		: std_area; // [R5]

	always_comb begin
		lay.comp_addr = base_r + {16'h0000, sel_off}; // [R22]
		lay.comp_size = sel_size;
		lay.comp_in_area = sel_ok && comp_in[idx];
		lay.comp_present = sel_ok && (idx < 3'(FIRST_EXT) || comp_in[idx]) &&
			present_lo_r[idx]; // [R9]
		lay.compacted = compacted;
		lay.restore_compacted = compacted; // [R11]
	end

	assign region = region_of(probe_r); // [R3] [R8] [R13]

	// read mux uses live values so a write just before a read is seen
	always_comb begin
		rd_word = 32'h00000000;
		case (rd_addr_r)
			A_BASE: rd_word = base_r;
			A_PRESENT_LO: rd_word = present_lo_r;
			A_PRESENT_HI: rd_word = present_hi_r;
			A_COMPACT_LO: rd_word = compact_lo_r;
			A_COMPACT_HI: rd_word = compact_hi_r;
			A_USER_MASK: rd_word = user_mask_r;
			A_SUPV_MASK: rd_word = supv_mask_r;
			A_COMP_SEL: rd_word = {26'h0000000, sel_r};
			A_COMP_OFFSET: rd_word = {16'h0000, sel_off};
			A_COMP_ADDR: rd_word = lay.comp_addr;
			A_COMP_SIZE: rd_word = {16'h0000, sel_size};
			A_STATUS: begin
				rd_word[ST_COMPACTED] = compacted;
				rd_word[ST_RESTORE_COMPACTED] = lay.restore_compacted;
				rd_word[ST_PRESENT] = lay.comp_present;
				rd_word[ST_IN_AREA] = lay.comp_in_area;
				rd_word[ST_MISALIGNED] = misalign_r;
				rd_word[ST_FMT_ERR] = fmt_err;
			end
			A_AREA_SIZE: rd_word = {16'h0000, area_size};
			A_CAPS: rd_word[CAPS_COMPACT_BIT] = COMPACT_SUPPORT; // [R20]
			A_PROBE_OFF: rd_word = {16'h0000, probe_r};
			A_PROBE_REGION: rd_word = {29'h00000000, region_r};
			default: rd_word = 32'h00000000;
		endcase
	end

	// bus phase tracking: writes take no wait state, reads take one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_pend_r <= 1'b0;
			rd_addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
		end else begin
			wr_pend_r <= xfer && hwrite && (hsize == 3'h2);
			rd_pend_r <= xfer && !hwrite;
			if (xfer) begin
				wr_addr_r <= {haddr[7:2], 2'b00};
				rd_addr_r <= {haddr[7:2], 2'b00};
			end
			hreadyout_r <= !(xfer && !hwrite);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_word;
		end
	end

	// software-written state; the low base bits are forced to the 64-byte grid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_r <= BASE_RST;
			misalign_r <= 1'b0;
			present_lo_r <= BITMAP_RST;
			present_hi_r <= BITMAP_RST;
			compact_lo_r <= BITMAP_RST;
			compact_hi_r <= BITMAP_RST;
			user_mask_r <= USER_MASK_RST;
			supv_mask_r <= SUPV_MASK_RST;
			sel_r <= SEL_RST;
			probe_r <= PROBE_RST;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				A_BASE: begin
					base_r <= {hwdata[31:ALIGN_BITS], {ALIGN_BITS{1'b0}}}; // [R1]
					misalign_r <= (hwdata[ALIGN_BITS-1:0] != '0);
				end
				A_PRESENT_LO: present_lo_r <= hwdata;
				A_PRESENT_HI: present_hi_r <= hwdata;
				// not checked against support; software keeps it clear [R12]
				A_COMPACT_LO: compact_lo_r <= hwdata;
				A_COMPACT_HI: compact_hi_r <= hwdata;
				A_USER_MASK: user_mask_r <= hwdata;
				A_SUPV_MASK: supv_mask_r <= hwdata;
				A_COMP_SEL: sel_r <= hwdata[5:0];
				A_PROBE_OFF: probe_r <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			layout_r <= '0;
			region_r <= RG_FP;
		end else begin
			layout_r <= lay;
			region_r <= region;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = 1'b0;
	assign layout = layout_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	base_aligned_a: assert property ( // [R1]
		layout.comp_addr[ALIGN_BITS-1:0] == '0 || layout.comp_in_area == 1'b0 ||
		$past(sel_off[ALIGN_BITS-1:0]) != '0)
		else $error("component address off the 64-byte grid");
	fp_bytes_a: assert property ( // [R6]
		(probe_r <= FP_LO_END || (probe_r > SIMD_LO_END && probe_r <= FP_HI_END))
		|=> region_r == RG_FP)
		else $error("fp stack bytes misclassified");
	simd_bytes_a: assert property ( // [R7]
		((probe_r > FP_LO_END && probe_r <= SIMD_LO_END) ||
		(probe_r > FP_HI_END && probe_r <= SIMD_HI_END)) |=> region_r == RG_SIMD)
		else $error("simd bytes misclassified");
	legacy_tail_a: assert property ( // [R8]
		(probe_r > SIMD_HI_END && probe_r <= LEGACY_END) |=>
		(region_r == ($past(probe_r) <= RSVD_END ? RG_RSVD : RG_UNUSED)))
		else $error("legacy tail misclassified");
	header_map_a: assert property ( // [R3]
		(probe_r >= HDR_OFF && probe_r < EXT_OFF) |=>
		region_r inside {RG_PRESENT, RG_COMPACT, RG_HDR_RSVD})
		else $error("header bytes misclassified");
	first_ext_a: assert property ( // [R16]
		(compacted && sel_r == 6'(FIRST_EXT) && cbits[FIRST_EXT]) |=>
		layout.comp_addr == $past(base_r) + {16'h0000, EXT_OFF})
		else $error("first compacted component not at 576");
	std_offset_a: assert property ( // [R14]
		(!compacted && sel_r == 6'(FIRST_EXT)) |=>
		layout.comp_addr == $past(base_r) + {16'h0000, COMP_STD_OFF_TBL[FIRST_EXT]})
		else $error("standard offset wrong");
	omit_clear_a: assert property ( // [R15]
		(compacted && sel_ok && idx >= 3'(FIRST_EXT) && !cbits[idx]) |=>
		!layout.comp_in_area && !layout.comp_present)
		else $error("cleared component kept in compacted area");
	restore_form_a: assert property ( // [R11]
		layout.restore_compacted == ($past(compact_hi_r[FORMAT_BIT]) && COMPACT_SUPPORT))
		else $error("restore form not following format bit");
	read_wait_a: assert property (
		(xfer && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_no_wait_a: assert property (
		(xfer && hwrite) |=> hreadyout)
		else $error("write took a wait state");
	legacy_place_a: assert property ( // [R2]
		(sel_ok && idx < 3'(FIRST_EXT)) |=>
		layout.comp_addr == $past(base_r) && layout.comp_size == LEGACY_SIZE)
		else $error("legacy component misplaced");
	ext_region_a: assert property ( // [R4]
		(probe_r >= EXT_OFF) |=> region_r == RG_EXT)
		else $error("extended bytes misclassified");
	base_grid_a: assert property ( // [R1]
		(wr_pend_r && wr_addr_r == A_BASE) |=> base_r[ALIGN_BITS-1:0] == '0 &&
		misalign_r == ($past(hwdata[ALIGN_BITS-1:0]) != '0))
		else $error("base write not forced to the grid");
	std_area_a: assert property ( // [R4] [R5]
		!compacted |-> area_size >= EXT_OFF)
		else $error("standard area shorter than the fixed regions");
endmodule

// ==== verification/area_memory.sv ====
/*
 * behavioural model of the memory that holds the save area.
 * assumes the layout output is registered on hclk; it flags any component
 * window that would spill into the 64-byte header.
 */
`timescale 1ns/1ns
module area_memory (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// area placement
	input wire logic [31:0] area_base,
	input layout_pkg::layout_t layout,
	// sticky clash flag
	output logic hdr_clash
);
	import layout_pkg::*;
	logic [32:0] lo_end;
	logic [32:0] hdr_lo;
	logic [32:0] hdr_hi;

	assign lo_end = {1'b0, layout.comp_addr} + {17'h0, layout.comp_size};
	assign hdr_lo = {1'b0, area_base} + {17'h0, HDR_OFF};
	assign hdr_hi = {1'b0, area_base} + {17'h0, EXT_OFF};

	// legacy part ends exactly where the header starts, so touching is fine
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdr_clash <= 1'b0;
		end else if ({1'b0, layout.comp_addr} < hdr_hi && lo_end > hdr_lo) begin
			hdr_clash <= 1'b1;
		end
	end
endmodule

// ==== verification/state_save_area_layout_tb.sv ====
/*
 * self-checking bench for the save-area layout block, register tests over ahb-lite.
 * assumes the single slave drives the bus hready and the memory model sees the layout.
 */
`timescale 1ns/1ns
module state_save_area_layout_tb;
	import layout_pkg::*;
	localparam logic [31:0] BASE_A = 32'h00001000;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hdr_clash;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	layout_t layout;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [15:0] poff [19] = '{16'h0000, 16'h0017, 16'h0018, 16'h001f, 16'h0020, 16'h009f,
		16'h00a0, 16'h019f, 16'h01a0, 16'h01cf, 16'h01d0, 16'h01ff, 16'h0200, 16'h0207,
		16'h0208, 16'h020f, 16'h0210, 16'h023f, 16'h0240};
	logic [2:0] preg [19] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h3,
		3'h2, 3'h2, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7};

	state_save_area_layout uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .layout(layout)
	);
	area_memory mem (
		.hclk(hclk), .hresetn(hresetn), .area_base(BASE_A), .layout(layout),
		.hdr_clash(hdr_clash)
	);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic give_verdict;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// one single word transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		chk(nm, e, x & m);
	endtask

	// a hang ends the run well past the few hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("user_mask", A_USER_MASK, 32'h1);
		rchk("supv_mask", A_SUPV_MASK, 32'h0);
		rchk("caps", A_CAPS, 32'h2, 32'h2);
		rchk("compact_rst", A_COMPACT_LO, 32'h0);
		wr(A_BASE, BASE_A);
		rchk("base", A_BASE, BASE_A);
		wr(A_COMP_SEL, 32'h0);
		rchk("sel", A_COMP_SEL, 32'h0);
		rchk("offset0", A_COMP_OFFSET, 32'h0);
		rchk("size0", A_COMP_SIZE, 32'h200);
		rchk("addr0", A_COMP_ADDR, BASE_A);
		// probe offset is registered, so read it back before the region
		for (int i = 0; i < 19; i++) begin
			wr(A_PROBE_OFF, {16'h0, poff[i]});
			rchk("probe_off", A_PROBE_OFF, {16'h0, poff[i]});
			rchk("region", A_PROBE_REGION, {29'h0, preg[i]}, 32'h7);
		end
		wr(A_COMP_SEL, 32'h2);
		wr(A_PRESENT_LO, 32'h4);
		wr(A_USER_MASK, 32'h5);
		wr(A_COMP_OFFSET, 32'hffffffff);
		rchk("present_lo", A_PRESENT_LO, 32'h4);
		rchk("offset2", A_COMP_OFFSET, 32'h240);
		rchk("addr2", A_COMP_ADDR, BASE_A + 32'h240);
		rchk("size2", A_COMP_SIZE, 32'h100);
		rchk("area_std", A_AREA_SIZE, 32'h340);
		rchk("status_std", A_STATUS, 32'h0c, 32'h3f);
		chk("layout_present", 32'h1, {31'h0, layout.comp_present});
		chk("layout_addr", BASE_A + 32'h240, layout.comp_addr);
		chk("layout_size", 32'h100, {16'h0, layout.comp_size});
		wr(A_USER_MASK, 32'h1);
		rchk("user_mask1", A_USER_MASK, 32'h1);
		rchk("area_min", A_AREA_SIZE, 32'h240);
		wr(A_SUPV_MASK, 32'h4);
		rchk("supv_mask4", A_SUPV_MASK, 32'h4);
		rchk("area_supv", A_AREA_SIZE, 32'h340);
		wr(A_SUPV_MASK, 32'h0);
		wr(A_COMPACT_LO, 32'h4);
		wr(A_COMPACT_HI, 32'h80000000);
		rchk("compact_hi", A_COMPACT_HI, 32'h80000000);
		rchk("status_cmp", A_STATUS, 32'h0f, 32'h3f);
		rchk("offset_cmp", A_COMP_OFFSET, 32'h240);
		rchk("area_cmp", A_AREA_SIZE, 32'h340);
		chk("layout_fmt", 32'h3, {30'h0, layout.compacted, layout.restore_compacted});
		wr(A_COMPACT_LO, 32'h0);
		rchk("compact_lo", A_COMPACT_LO, 32'h0);
		rchk("status_omit", A_STATUS, 32'h03, 32'h3f);
		rchk("area_omit", A_AREA_SIZE, 32'h240);
		chk("layout_in_area", 32'h0, {31'h0, layout.comp_in_area});
		wr(A_COMPACT_HI, 32'h0);
		rchk("compact_hi0", A_COMPACT_HI, 32'h0);
		rchk("status_back", A_STATUS, 32'h00, 32'h3f);
		wr(8'h40, 32'hffffffff);
		rchk("unmapped", 8'h40, 32'h0);
		// legacy component selected so the grid check sees an in-area address
		wr(A_COMP_SEL, 32'h0);
		wr(A_BASE, BASE_A + 32'h24);
		rchk("base_mis", A_BASE, BASE_A);
		rchk("status_mis", A_STATUS, 32'h18, 32'h3f);
		rchk("addr_mis", A_COMP_ADDR, BASE_A);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("header_clash", 32'h0, {31'h0, hdr_clash});
		// mid-run reset: base, status and layout size must fall back
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("base_rst", A_BASE, BASE_RST);
		rchk("status_rst", A_STATUS, 32'h08, 32'h3f);
		chk("layout_rst", {16'h0, LEGACY_SIZE}, {16'h0, layout.comp_size});
		give_verdict();
	end
endmodule
